// ### cch_config_control.sv
// Configuration control side-band: requester id, power state, errors, function reset
`timescale 1ns/1ps
module cch_config_control
  import cch_pkg::*;
#(
  parameter int PF_NUM = CCH_PF_NUM,
  parameter int VF_NUM = CCH_VF_NUM
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic downstreamMode,
  input wire logic [CCH_BUS_W-1:0] downstream_bus_num_in,
  input wire logic [CCH_DEV_W-1:0] downstream_dev_num_in,
  input wire logic [CCH_FN_W-1:0] downstream_fn_num_in,
  input wire logic [CCH_RID_W-1:0] upstreamRequesterId,
  input wire logic internalTlpReq,
  output logic [CCH_RID_W-1:0] internalRequesterId,
  input wire logic pmWriteValid,
  input wire logic pmWriteIsVirtual,
  input wire logic [CCH_EXT_FN_W-1:0] pmWriteFunction,
  input wire logic [CCH_PM_W-1:0] pmWriteState,
  input wire logic powerStateChangeAck,
  output logic powerStateChangeInd,
  output logic [CCH_EXT_FN_W-1:0] extFunctionNum,
  output logic cfgCompletionHold,
  output logic [PF_NUM*CCH_PM_W-1:0] physFnPmStateOut,
  output logic [VF_NUM*CCH_PM_W-1:0] virt_fn_pm_state_out,
  input wire logic corrErrIn,
  input wire logic uncorrErrIn,
  input wire logic [PF_NUM+VF_NUM-1:0] fnEnable,
  input wire logic [PF_NUM+VF_NUM-1:0] corrReportEnable,
  input wire logic [PF_NUM+VF_NUM-1:0] uncorrReportEnable,
  input wire logic [PF_NUM+VF_NUM-1:0] corrStatusClear,
  input wire logic [PF_NUM+VF_NUM-1:0] uncorrStatusClear,
  output logic [PF_NUM+VF_NUM-1:0] corrIntErrStatus,
  output logic [PF_NUM+VF_NUM-1:0] uncorrIntErrStatus,
  output logic corrErrMsg,
  output logic uncorrErrMsg,
  input wire logic [PF_NUM-1:0] physFnResetStart,
  input wire logic [PF_NUM-1:0] physFnResetDoneIn,
  output logic [PF_NUM-1:0] physFnResetActiveOut,
  input wire logic [VF_NUM-1:0] virtFnResetStart,
  input wire logic [VF_NUM-1:0] virt_fn_reset_done_in,
  output logic [VF_NUM-1:0] virt_fn_reset_active_out,
  output logic [PF_NUM-1:0] physFnCfgAccessEn,
  output logic [VF_NUM-1:0] virtFnCfgAccessEn
);

  function automatic logic isLowPower(input logic [CCH_PM_W-1:0] st);
    isLowPower = (st == CCH_PM_D1) || (st == CCH_PM_D3);
  endfunction

  // Requester id for internally generated TLPs
  logic [CCH_RID_W-1:0] rid_reg;
  logic [CCH_RID_W-1:0] rid_next;

  always_comb
  begin
    rid_next = rid_reg;
    if (internalTlpReq)
    begin
      if (downstreamMode)
        rid_next = {downstream_bus_num_in, downstream_dev_num_in,
          downstream_fn_num_in};
      else
        rid_next = upstreamRequesterId;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      rid_reg <= CCH_RID_RST;
    else
      rid_reg <= rid_next;
  end

  // Only the internal path sees it; streamed TLPs never pass here
  assign internalRequesterId = rid_reg;

  // Power state change handshake
  cch_ps_state_t ps_reg;
  cch_ps_state_t ps_next;
  logic [CCH_EXT_FN_W-1:0] fn_reg;
  logic [CCH_EXT_FN_W-1:0] fn_next;
  logic virt_reg;
  logic virt_next;
  logic [CCH_PM_W-1:0] newSt_reg;
  logic [CCH_PM_W-1:0] newSt_next;
  logic [PF_NUM*CCH_PM_W-1:0] pfPm_reg;
  logic [PF_NUM*CCH_PM_W-1:0] pfPm_next;
  logic [VF_NUM*CCH_PM_W-1:0] vfPm_reg;
  logic [VF_NUM*CCH_PM_W-1:0] vfPm_next;

  always_comb
  begin
    ps_next = ps_reg;
    fn_next = fn_reg;
    virt_next = virt_reg;
    newSt_next = newSt_reg;
    pfPm_next = pfPm_reg;
    vfPm_next = vfPm_reg;
    case (ps_reg)
      CCH_PS_IDLE:
      begin
        // Acknowledge with nothing pending is ignored
        if (pmWriteValid)
        begin
          fn_next = pmWriteFunction;
          virt_next = pmWriteIsVirtual;
          newSt_next = pmWriteState;
          if (isLowPower(pmWriteState))
            ps_next = CCH_PS_WAIT;
          else if (pmWriteIsVirtual)
          begin
            if (int'(pmWriteFunction) < VF_NUM)
              vfPm_next[int'(pmWriteFunction)*CCH_PM_W +: CCH_PM_W] = pmWriteState;
          end
          else if (int'(pmWriteFunction) < PF_NUM)
            pfPm_next[int'(pmWriteFunction)*CCH_PM_W +: CCH_PM_W] = pmWriteState;
        end
      end
      CCH_PS_WAIT:
      begin
        if (powerStateChangeAck)
        begin
          ps_next = CCH_PS_IDLE;
          if (virt_reg)
          begin
            if (int'(fn_reg) < VF_NUM)
              vfPm_next[int'(fn_reg)*CCH_PM_W +: CCH_PM_W] = newSt_reg;
          end
          else if (int'(fn_reg) < PF_NUM)
            pfPm_next[int'(fn_reg)*CCH_PM_W +: CCH_PM_W] = newSt_reg;
        end
      end
      default:
        ps_next = CCH_PS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ps_reg <= CCH_PS_IDLE;
      fn_reg <= CCH_EXT_FN_RST;
      virt_reg <= 1'b0;
      newSt_reg <= CCH_PM_D0;
      pfPm_reg <= '0;
      vfPm_reg <= '0;
    end
    else
    begin
      ps_reg <= ps_next;
      fn_reg <= fn_next;
      virt_reg <= virt_next;
      newSt_reg <= newSt_next;
      pfPm_reg <= pfPm_next;
      vfPm_reg <= vfPm_next;
    end
  end

  assign powerStateChangeInd = (ps_reg == CCH_PS_WAIT);
  assign cfgCompletionHold = (ps_reg == CCH_PS_WAIT);
  assign extFunctionNum = fn_reg;
  assign physFnPmStateOut = pfPm_reg;
  assign virt_fn_pm_state_out = vfPm_reg;

  // Internal error reports, shared by every enabled function
  cch_err_report #(
    .N(PF_NUM + VF_NUM)
  ) u_corr (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .errIn(corrErrIn),
    .fnEnable(fnEnable),
    .reportEnable(corrReportEnable),
    .statusClear(corrStatusClear),
    .statusOut(corrIntErrStatus),
    .msgOut(corrErrMsg)
  );

  cch_err_report #(
    .N(PF_NUM + VF_NUM)
  ) u_uncorr (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .errIn(uncorrErrIn),
    .fnEnable(fnEnable),
    .reportEnable(uncorrReportEnable),
    .statusClear(uncorrStatusClear),
    .statusOut(uncorrIntErrStatus),
    .msgOut(uncorrErrMsg)
  );

  // Function level reset tracking
  cch_reset_track #(
    .N(PF_NUM)
  ) u_pf_rst (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .startIn(physFnResetStart),
    .doneIn(physFnResetDoneIn),
    .activeOut(physFnResetActiveOut)
  );

  cch_reset_track #(
    .N(VF_NUM)
  ) u_vf_rst (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .startIn(virtFnResetStart),
    .doneIn(virt_fn_reset_done_in),
    .activeOut(virt_fn_reset_active_out)
  );

  assign physFnCfgAccessEn = ~physFnResetActiveOut;
  assign virtFnCfgAccessEn = ~virt_fn_reset_active_out;

endmodule

// ### cch_pkg.sv
// Shared constants and types for the configuration control handshake block
package cch_pkg;

  localparam int CCH_BUS_W = 8;
  localparam int CCH_DEV_W = 5;
  localparam int CCH_FN_W = 3;
  localparam int CCH_EXT_FN_W = 8;
  localparam int CCH_PF_NUM = 2;
  localparam int CCH_VF_NUM = 6;
  localparam int CCH_PM_W = 2;
  localparam int CCH_RID_W = 16;
  localparam logic [1:0] CCH_PM_D0 = 2'h0;
  localparam logic [1:0] CCH_PM_D1 = 2'h1;
  localparam logic [1:0] CCH_PM_D2 = 2'h2;
  localparam logic [1:0] CCH_PM_D3 = 2'h3;
  localparam logic [15:0] CCH_RID_RST = 16'h0000;
  localparam logic [7:0] CCH_EXT_FN_RST = 8'h00;

  typedef enum logic [1:0] {
    CCH_PS_IDLE = 2'b00,
    CCH_PS_WAIT = 2'b01
  } cch_ps_state_t;

endpackage

// ### cch_reset_track.sv
// Per-function reset in-progress tracker
`timescale 1ns/1ps
module cch_reset_track
  import cch_pkg::*;
#(
  parameter int N = 2
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [N-1:0] startIn,
  input wire logic [N-1:0] doneIn,
  output logic [N-1:0] activeOut
);

  logic [N-1:0] active_reg;
  logic [N-1:0] active_next;

  always_comb
  begin
    // Start wins over a done on the same cycle; stray done ignored
    active_next = (active_reg & ~doneIn) | startIn;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      active_reg <= '0;
    else
      active_reg <= active_next;
  end

  assign activeOut = active_reg;

endmodule

// ### cch_err_report.sv
// Internal error report fan-out to all enabled functions
`timescale 1ns/1ps
module cch_err_report
  import cch_pkg::*;
#(
  parameter int N = 8
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic errIn,
  input wire logic [N-1:0] fnEnable,
  input wire logic [N-1:0] reportEnable,
  input wire logic [N-1:0] statusClear,
  output logic [N-1:0] statusOut,
  output logic msgOut
);

  logic [N-1:0] status_reg;
  logic [N-1:0] status_next;
  logic msg_reg;
  logic msg_next;

  always_comb
  begin
    // Set wins over clear
    status_next = (status_reg & ~statusClear) | ({N{errIn}} & fnEnable);
    msg_next = errIn && |(fnEnable & reportEnable);
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      status_reg <= '0;
      msg_reg <= 1'b0;
    end
    else
    begin
      status_reg <= status_next;
      msg_reg <= msg_next;
    end
  end

  assign statusOut = status_reg;
  assign msgOut = msg_reg;

endmodule

// ### cch_config_control_asserts.sv
// Checker for the configuration control handshake ports
`timescale 1ns/1ps
module cch_config_control_asserts
  import cch_pkg::*;
#(
  parameter int PF_NUM = CCH_PF_NUM,
  parameter int VF_NUM = CCH_VF_NUM
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic downstreamMode,
  input wire logic [CCH_BUS_W-1:0] downstream_bus_num_in,
  input wire logic [CCH_DEV_W-1:0] downstream_dev_num_in,
  input wire logic [CCH_FN_W-1:0] downstream_fn_num_in,
  input wire logic internalTlpReq,
  input wire logic [CCH_RID_W-1:0] internalRequesterId,
  input wire logic pmWriteValid,
  input wire logic [CCH_EXT_FN_W-1:0] pmWriteFunction,
  input wire logic [CCH_PM_W-1:0] pmWriteState,
  input wire logic powerStateChangeAck,
  input wire logic powerStateChangeInd,
  input wire logic [CCH_EXT_FN_W-1:0] extFunctionNum,
  input wire logic cfgCompletionHold,
  input wire logic corrErrIn,
  input wire logic [PF_NUM+VF_NUM-1:0] fnEnable,
  input wire logic [PF_NUM+VF_NUM-1:0] corrIntErrStatus,
  input wire logic [PF_NUM-1:0] physFnResetStart,
  input wire logic [PF_NUM-1:0] physFnResetDoneIn,
  input wire logic [PF_NUM-1:0] physFnResetActiveOut
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_rid_down: assert property (internalTlpReq && downstreamMode |=>
    internalRequesterId == {$past(downstream_bus_num_in), $past(downstream_dev_num_in),
    $past(downstream_fn_num_in)}) else $error("requester id wrong");
  a_ind_raise: assert property (pmWriteValid && !powerStateChangeInd &&
    (pmWriteState == CCH_PM_D1 || pmWriteState == CCH_PM_D3) |=> powerStateChangeInd
    && extFunctionNum == $past(pmWriteFunction)) else $error("indication not raised");
  a_ind_hold: assert property (powerStateChangeInd && !powerStateChangeAck |=>
    powerStateChangeInd) else $error("indication dropped early");
  a_ind_drop: assert property (powerStateChangeInd && powerStateChangeAck |=>
    !powerStateChangeInd) else $error("indication not dropped");
  a_hold_follows: assert property (cfgCompletionHold == powerStateChangeInd)
    else $error("hold differs");
  a_ack_ignored: assert property (!powerStateChangeInd && !pmWriteValid |=>
    !powerStateChangeInd) else $error("indication without write");
  a_corr_set: assert property (corrErrIn |=>
    (corrIntErrStatus & $past(fnEnable)) == $past(fnEnable)) else $error("status not set");
  a_pf_rise: assert property (physFnResetStart[0] |=> physFnResetActiveOut[0])
    else $error("reset active not raised");
  a_pf_clear: assert property (physFnResetDoneIn[0] && !physFnResetStart[0] |=>
    !physFnResetActiveOut[0]) else $error("reset active not cleared");
endmodule
bind cch_config_control cch_config_control_asserts #(.PF_NUM(PF_NUM), .VF_NUM(VF_NUM)) chk (
  .clk_sys, .nrst, .downstreamMode, .downstream_bus_num_in, .downstream_dev_num_in,
  .downstream_fn_num_in, .internalTlpReq, .internalRequesterId, .pmWriteValid,
  .pmWriteFunction, .pmWriteState, .powerStateChangeAck, .powerStateChangeInd,
  .extFunctionNum, .cfgCompletionHold, .corrErrIn, .fnEnable, .corrIntErrStatus,
  .physFnResetStart, .physFnResetDoneIn, .physFnResetActiveOut);

// ### cch_user_model.sv
// User application model answering power and reset handshakes
`timescale 1ns/1ps
module cch_user_model
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic slow,
  input wire logic tie,
  input wire logic ind,
  input wire logic [1:0] pfAct,
  input wire logic [5:0] vfAct,
  output logic ack,
  output logic [1:0] pfDone,
  output logic [5:0] vfDone
);
  logic ackReg;
  logic [3:0] cnt;
  assign ack = tie | ackReg;
  always @(negedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      {ackReg, pfDone, vfDone, cnt} <= '0;
    end
    else
    begin
      {ackReg, pfDone, vfDone} <= '0;
      cnt <= '0;
      if (!ackReg && pfDone == 0 && vfDone == 0 && (ind || pfAct != 0 || vfAct != 0))
      begin
        cnt <= cnt + 4'h1;
        if (cnt >= (slow ? 4'h8 : 4'h1))
        begin
          {ackReg, pfDone, vfDone} <= {ind, pfAct, vfAct};
        end
      end
    end
  end
endmodule

// ### tb_top.sv
// Testbench for the configuration control handshake block
`timescale 1ns/1ps
module tb_top;
  import cch_pkg::*;
  logic clk_sys = 0, nrst = 0, downstreamMode = 0, internalTlpReq = 0, pmWriteValid = 0;
  logic pmWriteIsVirtual = 0, corrErrIn = 0, uncorrErrIn = 0, tie = 0, slow = 0, tbAck = 0;
  logic [7:0] downstream_bus_num_in = 0, pmWriteFunction = 0, fnEnable = 0, corrReportEnable = 0;
  logic [4:0] downstream_dev_num_in = 0;
  logic [2:0] downstream_fn_num_in = 0;
  logic [1:0] pmWriteState = 0, physFnResetStart = 0, physFnResetDoneIn, physFnResetActiveOut;
  logic [5:0] virtFnResetStart = 0, virt_fn_reset_done_in, virt_fn_reset_active_out;
  logic [1:0] physFnCfgAccessEn;
  logic [5:0] virtFnCfgAccessEn;
  logic [15:0] internalRequesterId;
  logic [7:0] extFunctionNum, corrIntErrStatus, uncorrIntErrStatus;
  logic [3:0] physFnPmStateOut;
  logic [11:0] virt_fn_pm_state_out;
  logic mAck, powerStateChangeInd, cfgCompletionHold, corrErrMsg, uncorrErrMsg;
  int num_errors = 0;
  int n_compared = 0;
  always #2.5 clk_sys = ~clk_sys;
  cch_user_model um (.clk_sys, .nrst, .slow, .tie, .ind(powerStateChangeInd),
    .pfAct(physFnResetActiveOut), .vfAct(virt_fn_reset_active_out), .ack(mAck),
    .pfDone(physFnResetDoneIn), .vfDone(virt_fn_reset_done_in));
  cch_config_control dut (.clk_sys, .nrst, .downstreamMode, .downstream_bus_num_in,
    .downstream_dev_num_in, .downstream_fn_num_in, .upstreamRequesterId(16'hA5C3),
    .internalTlpReq, .internalRequesterId, .pmWriteValid, .pmWriteIsVirtual, .pmWriteFunction,
    .pmWriteState, .powerStateChangeAck(mAck | tbAck), .powerStateChangeInd, .extFunctionNum,
    .cfgCompletionHold, .physFnPmStateOut, .virt_fn_pm_state_out, .corrErrIn, .uncorrErrIn,
    .fnEnable, .corrReportEnable, .uncorrReportEnable(8'hFF), .corrStatusClear(8'h00),
    .uncorrStatusClear(8'h00), .corrIntErrStatus, .uncorrIntErrStatus, .corrErrMsg,
    .uncorrErrMsg, .physFnResetStart, .physFnResetDoneIn, .physFnResetActiveOut,
    .virtFnResetStart, .virt_fn_reset_done_in, .virt_fn_reset_active_out, .physFnCfgAccessEn,
    .virtFnCfgAccessEn);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic stop_test;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic pm(input logic v, input logic [7:0] f, input logic [1:0] s);
    int i;
    {pmWriteIsVirtual, pmWriteFunction, pmWriteState, pmWriteValid} = {v, f, s, 1'b1};
    tick(1);
    {pmWriteValid, tbAck} = 2'b00;
    check(powerStateChangeInd, s[0]);
    if (s[0])
    begin
      check(cfgCompletionHold, 1'b1);
      check(extFunctionNum, f);
    end
    if (s[0] && slow)
    begin
      tick(4);
      check(powerStateChangeInd, 1'b1);
    end
    for (i = 0; i < 20 && powerStateChangeInd; i++)
      tick(1);
    check(v ? virt_fn_pm_state_out[f*2+:2] : physFnPmStateOut[f*2+:2], s);
  endtask
  initial
  begin
    tick(8);
    nrst = 1;
    for (int m = 0; m < 2; m++)
    begin
      {downstreamMode, downstream_bus_num_in, internalTlpReq} = {m[0], 8'hC5, 1'b1};
      {downstream_dev_num_in, downstream_fn_num_in} = {5'h1B, 3'h6};
      tick(1);
      internalTlpReq = 0;
      check(internalRequesterId, m ? 16'hC5DE : 16'hA5C3);
    end
    for (int s = 0; s < 4; s++)
    begin
      slow = s[1];
      pm(1'b0, 8'h01, s[1:0]);
      pm(1'b1, 8'h04, s[1:0]);
    end
    tbAck = 1;
    pm(1'b1, 8'h05, CCH_PM_D1);
    {tie, slow} = 2'b10;
    pm(1'b0, 8'h00, CCH_PM_D3);
    {tie, slow, fnEnable, corrReportEnable} = {2'b00, 8'h5A, 8'h80};
    {corrErrIn, uncorrErrIn} = 2'b11;
    tick(1);
    {corrErrIn, uncorrErrIn} = 2'b00;
    check(corrIntErrStatus, 8'h5A);
    check(uncorrIntErrStatus, 8'h5A);
    check({corrErrMsg, uncorrErrMsg}, 2'b01);
    {physFnResetStart, virtFnResetStart} = {2'h3, 6'h21};
    tick(1);
    {physFnResetStart, virtFnResetStart} = '0;
    check({physFnResetActiveOut, virt_fn_reset_active_out}, {2'h3, 6'h21});
    check({physFnCfgAccessEn, virtFnCfgAccessEn}, {2'h0, 6'h1E});
    tick(1);
    check(physFnResetActiveOut, 2'h3);
    tick(1);
    check({physFnResetActiveOut, virt_fn_reset_active_out}, 8'h00);
    check({physFnCfgAccessEn, virtFnCfgAccessEn}, 8'hFF);
    stop_test;
  end
  initial
  begin
    #5000;
    num_errors++;
    stop_test;
  end
endmodule
